// >>> main_timer.sv
// main timer: 16-bit free-running counter, prescaler, wrap flag, bypass, axi4-lite slave
`default_nettype none
// What this block does
// R01: counter advances through prescaler chosen by two-bit field; 00 gives 1, 11 gives 16.
// R02: prescale code 01 divides by 4, code 10 divides by 8.
// R03: after reset prescale is divide-by-1, counting every clock.
// R04: normal mode: prescale changes once, only in first 64 cycles after reset.
// R05: wrap flag sets whenever counter rolls from all ones to zero.
// R06: writing one to bit 7 of flag register 2 clears flag; zero leaves it.
// R07: with irq enable one, a set flag requests an interrupt; with it zero, irq comes only from irq status and its own enable.
// R08: wrap flag behaves the same whatever the irq enable bit.
// R09: counter keeps running after wrap even with flag still set.
// R10: bypass bit writable only in special modes; normal-mode writes ignored.
// R11: bypass skips prescaler and clocks both counter halves every cycle.
// R12: interrupt request stays high while flag and enable are both one.
// R13: counter starts at zero, counts up; normal mode cannot load or halt it.
// R14: reading high byte freezes low-byte buffer until the next read is taken, for matched read.
module main_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	logic [15:0] count_r;
	logic [3:0] presc_cnt_r;
	main_timer_pkg::timer_ctrl_s ctrl_r;
	logic presc_locked_r;
	logic [6:0] age_r;
	logic wrap_flag_r;
	logic bypass_r;
	logic special_mode_r;
	logic [7:0] low_buf_r;
	logic low_freeze_r;
	logic irq_status_r;
	logic irq_enable_r;
	logic [7:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;

	// prescaler tick
	logic [3:0] div_max;
	logic tick;
	logic wrap;
	assign div_max = (ctrl_r.prescale == 2'h0) ? main_timer_pkg::DIV_MAX_1 : // see R01
		(ctrl_r.prescale == 2'h1) ? main_timer_pkg::DIV_MAX_4 : // see R02
		(ctrl_r.prescale == 2'h2) ? main_timer_pkg::DIV_MAX_8 : // see R02
		main_timer_pkg::DIV_MAX_16; // see R01
	assign tick = bypass_r || (presc_cnt_r >= div_max); // see R11
	assign wrap = tick && (count_r == main_timer_pkg::COUNTER_ALL_ONES); // see R05

	// write channel
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
	assign wr_data = w_have_r ? w_data_r : s_axi_wdata;
	assign wr_strb = w_have_r ? w_strb_r : s_axi_wstrb;
	assign wr_fire = (aw_have_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_have_r || (s_axi_wvalid && s_axi_wready));
	logic wr_b0;
	assign wr_b0 = wr_fire && wr_strb[0];
	logic wr_mask2;
	logic wr_flag2;
	logic wr_test;
	logic wr_iclr;
	logic wr_ien;
	logic wr_mode;
	logic wr_known;
	assign wr_mask2 = wr_b0 && (wr_addr == main_timer_pkg::ADDR_MASK2);
	assign wr_flag2 = wr_b0 && (wr_addr == main_timer_pkg::ADDR_FLAG2);
	assign wr_test = wr_b0 && (wr_addr == main_timer_pkg::ADDR_TEST);
	assign wr_iclr = wr_b0 && (wr_addr == main_timer_pkg::ADDR_IRQ_CLEAR);
	assign wr_ien = wr_b0 && (wr_addr == main_timer_pkg::ADDR_IRQ_ENABLE);
	assign wr_mode = wr_b0 && (wr_addr == main_timer_pkg::ADDR_MODE);
	assign wr_known = (wr_addr == main_timer_pkg::ADDR_MASK2) || (wr_addr == main_timer_pkg::ADDR_FLAG2) ||
		(wr_addr == main_timer_pkg::ADDR_TEST) || (wr_addr == main_timer_pkg::ADDR_IRQ_CLEAR) ||
		(wr_addr == main_timer_pkg::ADDR_IRQ_ENABLE) || (wr_addr == main_timer_pkg::ADDR_MODE) ||
		(wr_addr == main_timer_pkg::ADDR_COUNTER) || (wr_addr == main_timer_pkg::ADDR_COUNTER_HI) ||
		(wr_addr == main_timer_pkg::ADDR_COUNTER_LO) || (wr_addr == main_timer_pkg::ADDR_IRQ_STATUS);

	// prescale write permission
	logic presc_ok;
	logic [1:0] presc_new;
	assign presc_new = wr_data[main_timer_pkg::PRESCALE_LO_BIT +: 2];
	assign presc_ok = special_mode_r || (!presc_locked_r && (age_r < main_timer_pkg::PROTECT_WINDOW_CYCLES)); // see R04
	logic wrap_clear;
	assign wrap_clear = wr_flag2 && wr_data[main_timer_pkg::WRAP_FLAG_BIT]; // see R06

	// read channel
	logic rd_fire;
	logic [31:0] rd_word;
	logic rd_known;
	logic [7:0] low_view;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign low_view = low_freeze_r ? low_buf_r : count_r[7:0]; // see R14
	assign rd_known = wr_known_rd(s_axi_araddr);
	assign rd_word =
		(s_axi_araddr == main_timer_pkg::ADDR_COUNTER) ? {16'h0000, count_r} :
		(s_axi_araddr == main_timer_pkg::ADDR_COUNTER_HI) ? {24'h000000, count_r[15:8]} :
		(s_axi_araddr == main_timer_pkg::ADDR_COUNTER_LO) ? {24'h000000, low_view} :
		(s_axi_araddr == main_timer_pkg::ADDR_MASK2) ? {24'h000000, ctrl_r.wrap_irq_enable, 5'h00, ctrl_r.prescale} :
		(s_axi_araddr == main_timer_pkg::ADDR_FLAG2) ? {24'h000000, wrap_flag_r, 7'h00} :
		(s_axi_araddr == main_timer_pkg::ADDR_TEST) ? {29'h00000000, bypass_r, 2'h0} :
		(s_axi_araddr == main_timer_pkg::ADDR_IRQ_STATUS) ? {31'h00000000, irq_status_r} :
		(s_axi_araddr == main_timer_pkg::ADDR_IRQ_ENABLE) ? {31'h00000000, irq_enable_r} :
		(s_axi_araddr == main_timer_pkg::ADDR_MODE) ? {31'h00000000, special_mode_r} : 32'h00000000;
	logic rd_hi;
	assign rd_hi = rd_fire && (s_axi_araddr == main_timer_pkg::ADDR_COUNTER_HI);

	function automatic logic wr_known_rd(input logic [7:0] a);
		wr_known_rd = (a == main_timer_pkg::ADDR_MASK2) || (a == main_timer_pkg::ADDR_FLAG2) ||
			(a == main_timer_pkg::ADDR_TEST) || (a == main_timer_pkg::ADDR_IRQ_ENABLE) ||
			(a == main_timer_pkg::ADDR_MODE) || (a == main_timer_pkg::ADDR_COUNTER) ||
			(a == main_timer_pkg::ADDR_COUNTER_HI) || (a == main_timer_pkg::ADDR_COUNTER_LO) ||
			(a == main_timer_pkg::ADDR_IRQ_STATUS) || (a == main_timer_pkg::ADDR_IRQ_CLEAR);
	endfunction

	assign irq = ((wrap_flag_r && ctrl_r.wrap_irq_enable) || (irq_status_r && irq_enable_r)); // see R07 see R12

	// counter and prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= main_timer_pkg::COUNTER_RESET; // see R13
			presc_cnt_r <= 4'h0;
		end else begin
			presc_cnt_r <= tick ? 4'h0 : presc_cnt_r + 4'h1;
			if (tick) begin
				count_r <= count_r + 16'h0001; // see R09 see R13
			end
		end
	end

	// control, flags, protection window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.prescale <= main_timer_pkg::PRESCALE_RESET; // see R03
			ctrl_r.wrap_irq_enable <= 1'b0;
			presc_locked_r <= 1'b0;
			age_r <= 7'h00;
			wrap_flag_r <= 1'b0;
			bypass_r <= 1'b0;
			special_mode_r <= 1'b0;
			irq_status_r <= 1'b0;
			irq_enable_r <= 1'b0;
		end else begin
			if (age_r < main_timer_pkg::PROTECT_WINDOW_CYCLES) begin
				age_r <= age_r + 7'h01;
			end
			if (wr_mask2) begin
				ctrl_r.wrap_irq_enable <= wr_data[main_timer_pkg::WRAP_IRQ_EN_BIT];
				if (presc_ok) begin
					ctrl_r.prescale <= presc_new; // see R04
					presc_locked_r <= !special_mode_r;
				end
			end
			if (wrap) begin
				wrap_flag_r <= 1'b1; // see R05 see R08
			end else if (wrap_clear) begin
				wrap_flag_r <= 1'b0; // see R06
			end
			if (wrap) begin
				irq_status_r <= 1'b1;
			end else if (wr_iclr && wr_data[0]) begin
				irq_status_r <= 1'b0;
			end
			if (wr_ien) begin
				irq_enable_r <= wr_data[0];
			end
			if (wr_mode) begin
				special_mode_r <= wr_data[main_timer_pkg::SPECIAL_MODE_BIT];
			end
			if (wr_test && special_mode_r) begin
				bypass_r <= wr_data[main_timer_pkg::BYPASS_BIT]; // see R10
			end else if (wr_mode && !wr_data[main_timer_pkg::SPECIAL_MODE_BIT]) begin
				bypass_r <= 1'b0;
			end
		end
	end

	// low byte buffer freeze
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_buf_r <= 8'h00;
			low_freeze_r <= 1'b0;
		end else begin
			// held until the next read is taken: a following read cannot be accepted one cycle later
			if (rd_hi) begin
				low_freeze_r <= 1'b1; // see R14
				low_buf_r <= count_r[7:0];
			end else if (rd_fire) begin
				low_freeze_r <= 1'b0;
			end
		end
	end

	// axi write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= main_timer_pkg::RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? main_timer_pkg::RESP_OKAY : main_timer_pkg::RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_r <= 1'b1;
					aw_addr_r <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_r <= 1'b1;
					w_data_r <= s_axi_wdata;
					w_strb_r <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// axi read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= main_timer_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? main_timer_pkg::RESP_OKAY : main_timer_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	a_wrap_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn) wrap |=> wrap_flag_r) // see R05
		else $error("wrap flag not set after rollover");
	a_clear_one_only: assert property (@(posedge aclk) disable iff (!aresetn) // see R06
		(wr_flag2 && !wr_data[main_timer_pkg::WRAP_FLAG_BIT] && wrap_flag_r) |=> wrap_flag_r)
		else $error("flag cleared by zero write");
	a_clear_takes: assert property (@(posedge aclk) disable iff (!aresetn) (wrap_clear && !wrap) |=> !wrap_flag_r) // see R06
		else $error("flag not cleared");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // see R12
		(wrap_flag_r && ctrl_r.wrap_irq_enable) |-> irq)
		else $error("irq low while flag and enable set");
	a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn) // see R07
		(!ctrl_r.wrap_irq_enable && !(irq_status_r && irq_enable_r)) |-> !irq)
		else $error("irq high while masked");
	a_count_runs: assert property (@(posedge aclk) disable iff (!aresetn) // see R09
		(wrap_flag_r && tick) |=> count_r == $past(count_r) + 16'h0001)
		else $error("counter stalled");
	a_presc_locked: assert property (@(posedge aclk) disable iff (!aresetn) // see R04
		(!special_mode_r && (presc_locked_r || age_r >= main_timer_pkg::PROTECT_WINDOW_CYCLES)) |=> $stable(ctrl_r.prescale))
		else $error("prescale changed outside window");
	a_bypass_guard: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
		(!special_mode_r && !wr_mode) |=> $stable(bypass_r))
		else $error("bypass written in normal mode");
	a_bypass_tick: assert property (@(posedge aclk) disable iff (!aresetn) bypass_r |-> tick) // see R11
		else $error("bypass not counting each cycle");
	a_div16_gap: assert property (@(posedge aclk) disable iff (!aresetn) // see R01
		(tick && !special_mode_r && ctrl_r.prescale == 2'h3 && $stable(ctrl_r.prescale)) |=> !tick [*8])
		else $error("divide by 16 ticked early");
	a_low_frozen: assert property (@(posedge aclk) disable iff (!aresetn) rd_hi |=> low_view == $past(count_r[7:0])) // see R14
		else $error("low byte not frozen");
	a_freeze_holds: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
		(low_freeze_r && !rd_fire) |=> (low_freeze_r && $stable(low_buf_r)))
		else $error("low byte freeze released early");
	a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn) !tick |=> $stable(count_r)) // see R13
		else $error("counter moved without a tick");
	a_flag_stays: assert property (@(posedge aclk) disable iff (!aresetn) // see R08
		(wrap_flag_r && !wrap_clear) |=> wrap_flag_r)
		else $error("wrap flag dropped without a clear");
endmodule // main_timer
`default_nettype wire

// >>> main_timer_pkg.sv
// package: register map, field positions and constants of the main timer
`default_nettype none
package main_timer_pkg;
	localparam logic [7:0] ADDR_COUNTER = 8'h00;
	localparam logic [7:0] ADDR_MASK2 = 8'h04;
	localparam logic [7:0] ADDR_FLAG2 = 8'h08;
	localparam logic [7:0] ADDR_TEST = 8'h0c;
	localparam logic [7:0] ADDR_COUNTER_HI = 8'h10;
	localparam logic [7:0] ADDR_COUNTER_LO = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
	localparam logic [7:0] ADDR_MODE = 8'h24;
	localparam int WRAP_FLAG_BIT = 7;
	localparam int WRAP_IRQ_EN_BIT = 7;
	localparam int PRESCALE_LO_BIT = 0;
	localparam int BYPASS_BIT = 2;
	localparam int SPECIAL_MODE_BIT = 0;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] COUNTER_ALL_ONES = 16'hffff;
	localparam logic [3:0] DIV_MAX_1 = 4'h0;
	localparam logic [3:0] DIV_MAX_4 = 4'h3;
	localparam logic [3:0] DIV_MAX_8 = 4'h7;
	localparam logic [3:0] DIV_MAX_16 = 4'hf;
	localparam logic [6:0] PROTECT_WINDOW_CYCLES = 7'h40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [1:0] prescale;
		logic wrap_irq_enable;
	} timer_ctrl_s;
endpackage
`default_nettype wire

// >>> test_main_timer.sv
// testbench: main timer prescaler, wrap flag, interrupt and bypass over axi4-lite
`default_nettype none
module test_main_timer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_CNT = main_timer_pkg::ADDR_COUNTER;
	localparam logic [7:0] A_MSK = main_timer_pkg::ADDR_MASK2;
	localparam logic [7:0] A_FLG = main_timer_pkg::ADDR_FLAG2;
	localparam logic [7:0] A_TST = main_timer_pkg::ADDR_TEST;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	logic [31:0] d;
	logic [1:0] r;
	main_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	initial forever #2.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic hang(input int n);
		if (n > 60) begin
			n_mismatch++;
			$display("mismatch handshake exp done got hang");
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
		int n;
		logic ha, hw, hb;
		n = 0;
		hb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hb) begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready === 1'b1;
			hw = s_axi_wvalid && s_axi_wready === 1'b1;
			hb = s_axi_bvalid === 1'b1;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) s_axi_bready <= 1'b0;
			n++;
			hang(n);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
		int n;
		logic ha, hr;
		n = 0;
		hr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hr) begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready === 1'b1;
			hr = s_axi_rvalid === 1'b1;
			dt = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) s_axi_rready <= 1'b0;
			n++;
			hang(n);
		end
	endtask
	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic chk_irq(input logic e);
		@(negedge aclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// counter advance over an interval that is a whole number of sixteen cycles
	task automatic rate(input int dv);
		logic [31:0] c0;
		int t0;
		while (cyc % 16 != 0) @(posedge aclk);
		rd(A_CNT, c0, r);
		t0 = cyc;
		repeat (64) @(posedge aclk);
		while (cyc % 16 != 0) @(posedge aclk);
		rd(A_CNT, d, r);
		chk("count rate", (cyc - t0) / dv, (d - c0) & 32'hffff);
	endtask
	task automatic t_prescale();
		int dv[4] = '{1, 4, 8, 16};
		rst();
		rate(1);
		for (int c = 1; c < 4; c++) begin
			rst();
			wr(A_MSK, c, r);
			wr(A_MSK, 32'h0, r);
			rate(dv[c]);
		end
		rst();
		repeat (70) @(posedge aclk);
		wr(A_MSK, 32'h3, r);
		rate(1);
	endtask
	task automatic t_wrap();
		int n;
		rst();
		wr(A_MSK, 32'h80, r);
		wr(main_timer_pkg::ADDR_IRQ_ENABLE, 32'h0, r);
		rd(A_FLG, d, r);
		chk("flag before wrap", 32'h0, d & 32'h80);
		repeat (65300) @(posedge aclk);
		n = 0;
		d = 32'h0;
		while (d[7] !== 1'b1 && n < 300) begin
			rd(A_FLG, d, r);
			n++;
		end
		chk("flag after wrap", 32'h80, d & 32'h80);
		if (d[7] !== 1'b1) end_sim();
		chk_irq(1'b1);
		rd(A_CNT, d, r);
		chk("count resumes", 32'h1, {31'h0, d[15:0] < 16'h0400});
		rd(main_timer_pkg::ADDR_IRQ_STATUS, d, r);
		chk("irq status", 32'h1, d & 32'h1);
		wr(A_FLG, 32'h0, r);
		rd(A_FLG, d, r);
		chk("flag after zero write", 32'h80, d & 32'h80);
		wr(A_MSK, 32'h0, r);
		chk_irq(1'b0);
		rd(A_FLG, d, r);
		chk("flag with irq off", 32'h80, d & 32'h80);
		wr(main_timer_pkg::ADDR_IRQ_ENABLE, 32'h1, r);
		chk_irq(1'b1);
		wr(main_timer_pkg::ADDR_IRQ_CLEAR, 32'h1, r);
		chk_irq(1'b0);
		rd(main_timer_pkg::ADDR_IRQ_STATUS, d, r);
		chk("irq status cleared", 32'h0, d & 32'h1);
		wr(A_MSK, 32'h80, r);
		chk_irq(1'b1);
		wr(A_FLG, 32'h80, r);
		chk_irq(1'b0);
		rd(A_FLG, d, r);
		chk("flag cleared", 32'h0, d & 32'h80);
	endtask
	task automatic t_pair();
		logic [31:0] c0, hi;
		int t0, t1;
		rst();
		rd(A_CNT, c0, r);
		t0 = cyc;
		rd(main_timer_pkg::ADDR_COUNTER_HI, hi, r);
		t1 = cyc;
		rd(main_timer_pkg::ADDR_COUNTER_LO, d, r);
		chk("paired count", (c0 + t1 - t0) & 32'hffff, {16'h0000, hi[7:0], d[7:0]});
		rd(main_timer_pkg::ADDR_COUNTER_LO, d, r);
		t1 = cyc;
		chk("live low byte", (c0 + t1 - t0) & 32'hff, d);
	endtask
	task automatic t_bypass();
		rst();
		wr(A_TST, 32'h4, r);
		rd(A_TST, d, r);
		chk("bypass normal mode", 32'h0, d & 32'h4);
		wr(main_timer_pkg::ADDR_MODE, 32'h1, r);
		wr(A_MSK, 32'h3, r);
		wr(A_TST, 32'h4, r);
		rd(A_TST, d, r);
		chk("bypass special mode", 32'h4, d & 32'h4);
		rate(1);
		rd(8'h30, d, r);
		chk("unmapped read resp", {30'h0, main_timer_pkg::RESP_SLVERR}, {30'h0, r});
		chk("unmapped read data", 32'h0, d);
		wr(8'h30, 32'h1, r);
		chk("unmapped write resp", {30'h0, main_timer_pkg::RESP_SLVERR}, {30'h0, r});
	endtask
	initial begin
		t_prescale();
		t_bypass();
		t_pair();
		t_wrap();
		end_sim();
	end
endmodule // test_main_timer
`default_nettype wire
